/* File: rtl/wbclc_pkg.sv */
// Shared constants and types for the write-back cache line state control
package wbclc_pkg;
    localparam int          NUM_SETS    = 4;
    localparam int          NUM_WAYS    = 4;
    localparam int          LINE_WORDS  = 4;
    localparam int          WORD_W      = 32;
    localparam int          OFF_LSB     = 2;
    localparam int          IDX_LSB     = 4;
    localparam int          TAG_LSB     = 6;
    localparam int          TAG_W       = 26;
    localparam logic [1:0]  LS_INVALID  = 2'h0;
    localparam logic [1:0]  LS_EXCL     = 2'h1;
    localparam logic [1:0]  LS_MODIFIED = 2'h2;
    localparam logic [1:0]  LS_SHARED   = 2'h3;
    localparam logic [1:0]  LAST_BEAT   = 2'h3;
    localparam logic [2:0]  PLRU_RESET  = 3'h0;
    localparam logic [31:0] DATA_RESET  = 32'h0;
    localparam int          SNOOP_DELAY = 2;

    typedef enum logic [2:0] {
        FS_IDLE,
        FS_BUSWR,
        FS_NCREAD,
        FS_COPYBACK,
        FS_FILL,
        FS_SNOOPWB
    } wbclc_fsm_t;
endpackage : wbclc_pkg

/* File: rtl/wbclc_top.sv */
// Line state, replacement and write-back control of a four-way cache
// Operation
// - Only a cacheable read miss allocates a line; write misses never allocate.
// - Each line holds four 32-bit words, a tag and two status bits.
// - Status encoding 00 invalid, 01 exclusive, 10 modified, 11 shared.
// - Invalid lines hold no data and never hit a snoop.
// - A read hitting a valid tag is served without any bus access.
// - A write hitting a shared line updates the cache and memory.
// - A write hitting exclusive or modified updates only the cache.
// - A write miss goes straight to the bus, cache unchanged.
// - Modified data is written out on replacement and on snoop hit.
// - A snoop hitting modified forces the master off until write-back ends.
// - Shared also marks write-through lines.
// - Allocation uses an invalid way of the set when one exists.
// - Otherwise pseudo-LRU over the four ways picks the victim.
// - A modified victim goes to the copy-back buffer; new line fills the way.
// - In write-through operation every processor write also goes to the bus.
// - Fill ends exclusive if policy input high and page attribute low, else shared.
// - A write hitting an exclusive line makes it modified.
// - Snoop hit-modified is driven two clocks after the snoop strobe, modified only.
`timescale 1ns/1ps
module wbclc_top
    import wbclc_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        ARST_N,
    input  wire logic        CPU_REQ,
    input  wire logic        CPU_WE,
    input  wire logic        CPU_CACHEABLE,
    input  wire logic [31:0] CPU_ADDR,
    input  wire logic [31:0] CPU_WDATA,
    input  wire logic        PAGE_WRITETHROUGH_ATTR,
    output logic             CPU_READY,
    output logic      [31:0] CPU_RDATA,
    output logic             BUS_REQ,
    output logic             BUS_WE,
    output logic      [31:0] BUS_ADDR,
    output logic      [31:0] BUS_WDATA,
    input  wire logic        BUS_ACK,
    input  wire logic [31:0] BUS_RDATA,
    input  wire logic        LINE_POLICY_SELECT,
    input  wire logic        SNOOP_ADDRESS_STROBE,
    input  wire logic        SNOOP_INVALIDATE_REQ,
    input  wire logic [31:0] SNOOP_ADDR,
    output logic             SNOOP_HIT_MODIFIED,
    output logic             BUS_BACKOFF
);
    import wbclc_pkg::*;

    logic              rst_meta_r, rst_n_r;
    wbclc_fsm_t        fsm_r;
    logic [1:0]        line_state_r [NUM_SETS][NUM_WAYS];
    logic [TAG_W-1:0]  tag_r        [NUM_SETS][NUM_WAYS];
    logic [31:0]       data_r       [NUM_SETS][NUM_WAYS][LINE_WORDS];
    logic [2:0]        plru_r       [NUM_SETS];
    logic [31:0]       cb_data_r    [LINE_WORDS];
    logic [TAG_W-1:0]  cb_tag_r;
    logic [31:0]       req_addr_r;
    logic [1:0]        req_way_r, beat_r;
    logic              policy_r, wt_force_r;
    logic              cpu_ready_r, bus_req_r, bus_we_r, swb_done_r;
    logic [31:0]       cpu_rdata_r, bus_addr_r, bus_wdata_r;
    logic              sq_valid_r, sq_hit_r, sq_mod_r, sq_kill_r, snp_hm_r, swb_kill_r;
    logic [1:0]        sq_set_r, sq_way_r, swb_set_r, swb_way_r;
    logic [1:0]        c_set, c_off, s_set, hit_way, free_way, s_way, victim;
    logic [TAG_W-1:0]  c_tag, s_tag, req_tag;
    logic [1:0]        req_set, req_off;
    logic              hit, free_found, s_hit;

    assign c_set   = CPU_ADDR[IDX_LSB+1:IDX_LSB];
    assign c_off   = CPU_ADDR[OFF_LSB+1:OFF_LSB];
    assign c_tag   = CPU_ADDR[31:TAG_LSB];
    assign s_set   = SNOOP_ADDR[IDX_LSB+1:IDX_LSB];
    assign s_tag   = SNOOP_ADDR[31:TAG_LSB];
    assign req_set = req_addr_r[IDX_LSB+1:IDX_LSB];
    assign req_off = req_addr_r[OFF_LSB+1:OFF_LSB];
    assign req_tag = req_addr_r[31:TAG_LSB];

    assign CPU_READY          = cpu_ready_r;
    assign CPU_RDATA          = cpu_rdata_r;
    assign BUS_REQ            = bus_req_r;
    assign BUS_WE             = bus_we_r;
    assign BUS_ADDR           = bus_addr_r;
    assign BUS_WDATA          = bus_wdata_r;
    assign SNOOP_HIT_MODIFIED = snp_hm_r;
    assign BUS_BACKOFF        = snp_hm_r;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Processor-side lookup: invalid ways never match
    always_comb begin
        hit       = 1'b0;
        hit_way   = 2'h0;
        free_found = 1'b0;
        free_way   = 2'h0;
        for (int w = 0; w < NUM_WAYS; w++) begin
            if (line_state_r[c_set][w] != LS_INVALID && tag_r[c_set][w] == c_tag) begin
                hit     = 1'b1;
                hit_way = 2'(w);
            end
            if (line_state_r[c_set][w] == LS_INVALID && !free_found) begin
                free_found = 1'b1;
                free_way   = 2'(w);
            end
        end
    end

    // Invalid way first, tree pseudo-LRU otherwise
    always_comb begin
        if (free_found) begin
            victim = free_way;
        end else if (!plru_r[c_set][0]) begin
            victim = plru_r[c_set][1] ? 2'h1 : 2'h0;
        end else begin
            victim = plru_r[c_set][2] ? 2'h3 : 2'h2;
        end
    end

    always_comb begin
        s_hit = 1'b0;
        s_way = 2'h0;
        for (int w = 0; w < NUM_WAYS; w++) begin
            if (line_state_r[s_set][w] != LS_INVALID && tag_r[s_set][w] == s_tag) begin
                s_hit = 1'b1;
                s_way = 2'(w);
            end
        end
    end

    function automatic logic [2:0] plru_touch(input logic [2:0] cur, input logic [1:0] way);
        logic [2:0] nxt;
        nxt = cur;
        if (!way[1]) begin
            nxt[0] = 1'b1;
            nxt[1] = ~way[0];
        end else begin
            nxt[0] = 1'b0;
            nxt[2] = ~way[0];
        end
        return nxt;
    endfunction : plru_touch

    // Snoop pipeline: lookup at the strobe edge, result out on the next edge
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sq_valid_r <= 1'b0;
            sq_hit_r   <= 1'b0;
            sq_mod_r   <= 1'b0;
            sq_kill_r  <= 1'b0;
            sq_set_r   <= 2'h0;
            sq_way_r   <= 2'h0;
            snp_hm_r   <= 1'b0;
            swb_set_r  <= 2'h0;
            swb_way_r  <= 2'h0;
            swb_kill_r <= 1'b0;
        end else begin
            sq_valid_r <= SNOOP_ADDRESS_STROBE;
            sq_hit_r   <= s_hit;
            sq_mod_r   <= s_hit && line_state_r[s_set][s_way] == LS_MODIFIED;
            sq_kill_r  <= SNOOP_INVALIDATE_REQ;
            sq_set_r   <= s_set;
            sq_way_r   <= s_way;
            // New hit wins over the clear of a finished write-back
            if (sq_valid_r && sq_mod_r) begin
                snp_hm_r   <= 1'b1;
                swb_set_r  <= sq_set_r;
                swb_way_r  <= sq_way_r;
                swb_kill_r <= sq_kill_r;
            end else if (swb_done_r) begin
                snp_hm_r <= 1'b0;
            end
        end
    end

    // Line arrays and transfer sequencing share one process: single writer per array
    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fsm_r       <= FS_IDLE;
            for (int s = 0; s < NUM_SETS; s++) begin
                plru_r[s] <= PLRU_RESET;
                for (int w = 0; w < NUM_WAYS; w++) begin
                    line_state_r[s][w] <= LS_INVALID;
                    tag_r[s][w]        <= '0;
                    for (int k = 0; k < LINE_WORDS; k++) data_r[s][w][k] <= DATA_RESET;
                end
            end
            for (int k = 0; k < LINE_WORDS; k++) cb_data_r[k] <= DATA_RESET;
            cb_tag_r    <= '0;
            req_addr_r  <= '0;
            req_way_r   <= 2'h0;
            beat_r      <= 2'h0;
            policy_r    <= 1'b0;
            wt_force_r  <= 1'b0;
            cpu_ready_r <= 1'b0;
            cpu_rdata_r <= DATA_RESET;
            bus_req_r   <= 1'b0;
            bus_we_r    <= 1'b0;
            bus_addr_r  <= '0;
            bus_wdata_r <= DATA_RESET;
            swb_done_r  <= 1'b0;
        end else begin
            cpu_ready_r <= 1'b0;
            swb_done_r  <= 1'b0;
            case (fsm_r)
                FS_IDLE: begin
                    beat_r <= 2'h0;
                    if (snp_hm_r && !swb_done_r) begin
                        fsm_r       <= FS_SNOOPWB;
                        bus_req_r   <= 1'b1;
                        bus_we_r    <= 1'b1;
                        bus_addr_r  <= {tag_r[swb_set_r][swb_way_r], swb_set_r, 2'h0, 2'h0};
                        bus_wdata_r <= data_r[swb_set_r][swb_way_r][0];
                    end else if (CPU_REQ && !cpu_ready_r && !snp_hm_r) begin
                        req_addr_r <= CPU_ADDR;
                        wt_force_r <= PAGE_WRITETHROUGH_ATTR;
                        if (CPU_WE && hit) begin
                            data_r[c_set][hit_way][c_off] <= CPU_WDATA;
                            plru_r[c_set] <= plru_touch(plru_r[c_set], hit_way);
                            if (line_state_r[c_set][hit_way] == LS_SHARED) begin
                                fsm_r       <= FS_BUSWR;
                                bus_req_r   <= 1'b1;
                                bus_we_r    <= 1'b1;
                                bus_addr_r  <= CPU_ADDR;
                                bus_wdata_r <= CPU_WDATA;
                            end else begin
                                line_state_r[c_set][hit_way] <= LS_MODIFIED;
                                cpu_ready_r <= 1'b1;
                            end
                        end else if (CPU_WE) begin
                            fsm_r       <= FS_BUSWR;
                            bus_req_r   <= 1'b1;
                            bus_we_r    <= 1'b1;
                            bus_addr_r  <= CPU_ADDR;
                            bus_wdata_r <= CPU_WDATA;
                        end else if (hit) begin
                            cpu_rdata_r   <= data_r[c_set][hit_way][c_off];
                            cpu_ready_r   <= 1'b1;
                            plru_r[c_set] <= plru_touch(plru_r[c_set], hit_way);
                        end else if (!CPU_CACHEABLE) begin
                            fsm_r      <= FS_NCREAD;
                            bus_req_r  <= 1'b1;
                            bus_we_r   <= 1'b0;
                            bus_addr_r <= CPU_ADDR;
                        end else begin
                            req_way_r <= victim;
                            bus_req_r <= 1'b1;
                            if (line_state_r[c_set][victim] == LS_MODIFIED) begin
                                // Victim stays modified and snoopable until its copy-back ends
                                for (int k = 0; k < LINE_WORDS; k++) cb_data_r[k] <= data_r[c_set][victim][k];
                                cb_tag_r    <= tag_r[c_set][victim];
                                fsm_r       <= FS_COPYBACK;
                                bus_we_r    <= 1'b1;
                                bus_addr_r  <= {tag_r[c_set][victim], c_set, 2'h0, 2'h0};
                                bus_wdata_r <= data_r[c_set][victim][0];
                            end else begin
                                fsm_r      <= FS_FILL;
                                bus_we_r   <= 1'b0;
                                bus_addr_r <= {c_tag, c_set, 2'h0, 2'h0};
                                line_state_r[c_set][victim] <= LS_INVALID;
                            end
                        end
                    end
                end
                FS_BUSWR, FS_NCREAD: begin
                    if (BUS_ACK) begin
                        bus_req_r   <= 1'b0;
                        cpu_ready_r <= 1'b1;
                        fsm_r       <= FS_IDLE;
                        if (fsm_r == FS_NCREAD) cpu_rdata_r <= BUS_RDATA;
                    end
                end
                FS_COPYBACK: begin
                    if (BUS_ACK) begin
                        beat_r <= beat_r + 2'h1;
                        if (beat_r == LAST_BEAT) begin
                            fsm_r      <= FS_FILL;
                            bus_we_r   <= 1'b0;
                            bus_addr_r <= {req_tag, req_set, 2'h0, 2'h0};
                            line_state_r[req_set][req_way_r] <= LS_INVALID;
                        end else begin
                            bus_addr_r  <= {cb_tag_r, req_set, beat_r + 2'h1, 2'h0};
                            bus_wdata_r <= cb_data_r[beat_r + 2'h1];
                        end
                    end
                end
                FS_FILL: begin
                    if (BUS_ACK) begin
                        data_r[req_set][req_way_r][beat_r] <= BUS_RDATA;
                        beat_r <= beat_r + 2'h1;
                        if (beat_r == req_off) cpu_rdata_r <= BUS_RDATA;
                        if (beat_r == 2'h0) policy_r <= LINE_POLICY_SELECT;
                        if (beat_r == LAST_BEAT) begin
                            // Policy sampled on the first beat of the fill
                            if ((beat_r == 2'h0 ? LINE_POLICY_SELECT : policy_r) && !wt_force_r) begin
                                line_state_r[req_set][req_way_r] <= LS_EXCL;
                            end else begin
                                line_state_r[req_set][req_way_r] <= LS_SHARED;
                            end
                            tag_r[req_set][req_way_r] <= req_tag;
                            plru_r[req_set] <= plru_touch(plru_r[req_set], req_way_r);
                            bus_req_r   <= 1'b0;
                            cpu_ready_r <= 1'b1;
                            fsm_r       <= FS_IDLE;
                        end else begin
                            bus_addr_r <= {req_tag, req_set, beat_r + 2'h1, 2'h0};
                        end
                    end
                end
                FS_SNOOPWB: begin
                    if (BUS_ACK) begin
                        beat_r <= beat_r + 2'h1;
                        if (beat_r == LAST_BEAT) begin
                            line_state_r[swb_set_r][swb_way_r] <= swb_kill_r ? LS_INVALID : LS_SHARED;
                            bus_req_r  <= 1'b0;
                            swb_done_r <= 1'b1;
                            fsm_r      <= FS_IDLE;
                        end else begin
                            bus_addr_r  <= {tag_r[swb_set_r][swb_way_r], swb_set_r, beat_r + 2'h1, 2'h0};
                            bus_wdata_r <= data_r[swb_set_r][swb_way_r][beat_r + 2'h1];
                        end
                    end
                end
                default: fsm_r <= FS_IDLE;
            endcase
            // Clean hits change state at once; modified hits wait for their write-back
            if (sq_valid_r && sq_hit_r && !sq_mod_r) begin
                line_state_r[sq_set_r][sq_way_r] <= sq_kill_r ? LS_INVALID : LS_SHARED;
            end
        end
    end
endmodule : wbclc_top

/* File: test/wbclc_checker.sv */
// Concurrent checks on the cache control ports
`timescale 1ns/1ps
module wbclc_checker (
    input wire logic        REF_CLK,
    input wire logic        ARST_N,
    input wire logic        CPU_REQ,
    input wire logic        CPU_READY,
    input wire logic        BUS_REQ,
    input wire logic        BUS_WE,
    input wire logic [31:0] BUS_ADDR,
    input wire logic [31:0] BUS_WDATA,
    input wire logic        BUS_ACK,
    input wire logic        SNOOP_ADDRESS_STROBE,
    input wire logic        SNOOP_HIT_MODIFIED,
    input wire logic        BUS_BACKOFF
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    hm_delay_a: assert property ($rose(SNOOP_HIT_MODIFIED) |-> $past(SNOOP_ADDRESS_STROBE, 2))
        else $error("hit-modified not two clocks after strobe");
    backoff_tie_a: assert property (BUS_BACKOFF == SNOOP_HIT_MODIFIED)
        else $error("backoff differs from hit-modified");
    hm_release_a: assert property ($fell(SNOOP_HIT_MODIFIED) |-> $past(BUS_REQ && BUS_ACK && BUS_WE, 2))
        else $error("hit-modified dropped without write-back end");
    writeback_start_a: assert property ($rose(SNOOP_HIT_MODIFIED) |-> ##[0:60] (BUS_REQ && BUS_WE))
        else $error("no write-back after snoop hit");
    beat_hold_a: assert property (BUS_REQ && !BUS_ACK |=> BUS_REQ && $stable(BUS_ADDR)
        && $stable(BUS_WE) && $stable(BUS_WDATA)) else $error("bus request changed before ack");
    beat_step_a: assert property (BUS_REQ && BUS_ACK && BUS_ADDR[3:2] != 2'h3
        |=> !BUS_REQ || BUS_ADDR == $past(BUS_ADDR) + 32'h4) else $error("line beat order broken");
    word_align_a: assert property (BUS_REQ |-> BUS_ADDR[1:0] == 2'h0)
        else $error("bus address not word aligned");
    reset_quiet_a: assert property ($rose(ARST_N) |-> !SNOOP_HIT_MODIFIED && !BUS_REQ && !CPU_READY)
        else $error("outputs active on reset release");
    ready_pulse_a: assert property (CPU_READY |-> CPU_REQ ##1 !CPU_READY)
        else $error("ready without request or longer than one cycle");

    cover property ($rose(SNOOP_HIT_MODIFIED));
    cover property (BUS_REQ && BUS_WE && BUS_ACK ##1 BUS_REQ && !BUS_WE);
    cover property (CPU_READY && !BUS_REQ);
endmodule : wbclc_checker

/* File: test/wbclc_mem_model.sv */
// Memory and bus responder on the far side of the cache
`timescale 1ns/1ps
module wbclc_mem_model #(
    parameter logic [31:0] FILL_XOR = 32'h1357_9bdf
) (
    input wire logic        clk,
    input wire logic        bus_req,
    input wire logic        bus_we,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic            bus_ack,
    output logic     [31:0] bus_rdata
);
    logic [31:0] mem [logic [31:0]];

    initial begin
        bus_ack = 1'b0;
        bus_rdata = 32'h0;
    end

    // Random ack gaps; rdata scrambled when not acking so stale data never looks valid
    always @(posedge clk) begin
        if (bus_req && bus_ack && bus_we) begin
            mem[bus_addr] = bus_wdata;
        end
        #1;
        if (bus_req && $urandom_range(2) != 0) begin
            bus_ack = 1'b1;
            bus_rdata = mem.exists(bus_addr) ? mem[bus_addr] : bus_addr ^ FILL_XOR;
        end else begin
            bus_ack = 1'b0;
            bus_rdata = ~bus_rdata;
        end
    end
endmodule : wbclc_mem_model

/* File: test/wbclc_top_tb_top.sv */
// Self-checking bench for the cache line state control
`timescale 1ns/1ps
module wbclc_top_tb_top;
    import wbclc_pkg::*;
    localparam logic [31:0] FILL_XOR = 32'h1357_9bdf;
    typedef struct { logic rd; logic [31:0] data; int nwr; int nrd; } wbclc_note_t;
    logic REF_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic cpu_req, cpu_we, cpu_cach, wt_attr, pol, strobe, snp_kill;
    logic cpu_ready, bus_req, bus_we, bus_ack, snp_hm, backoff;
    logic [31:0] cpu_addr, cpu_wdata, snp_addr, cpu_rdata, bus_addr, bus_wdata, bus_rdata, a;
    logic [31:0] view [logic [31:0]];
    wbclc_note_t notes[$];
    int miscompares = 0;
    int num_checks = 0;
    int nwr_seen = 0;
    int nrd_seen = 0;
    int i;

    always #10 REF_CLK = ~REF_CLK;

    wbclc_top wbclc_top_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CPU_REQ(cpu_req), .CPU_WE(cpu_we),
        .CPU_CACHEABLE(cpu_cach), .CPU_ADDR(cpu_addr), .CPU_WDATA(cpu_wdata), .PAGE_WRITETHROUGH_ATTR(wt_attr),
        .CPU_READY(cpu_ready), .CPU_RDATA(cpu_rdata), .BUS_REQ(bus_req), .BUS_WE(bus_we), .BUS_ADDR(bus_addr),
        .BUS_WDATA(bus_wdata), .BUS_ACK(bus_ack), .BUS_RDATA(bus_rdata), .LINE_POLICY_SELECT(pol),
        .SNOOP_ADDRESS_STROBE(strobe), .SNOOP_INVALIDATE_REQ(snp_kill), .SNOOP_ADDR(snp_addr),
        .SNOOP_HIT_MODIFIED(snp_hm), .BUS_BACKOFF(backoff));
    wbclc_mem_model #(.FILL_XOR(FILL_XOR)) wbclc_mem_model_i (.clk(REF_CLK), .bus_req(bus_req),
        .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

    function automatic logic [31:0] exp_word(input logic [31:0] ad);
        return view.exists(ad) ? view[ad] : ad ^ FILL_XOR;
    endfunction : exp_word

    function automatic logic [31:0] mk(input int tag, input int set, input int wd);
        return {tag[25:0], set[1:0], wd[1:0], 2'h0};
    endfunction : mk

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic cpu_op(input logic we, cach, input logic [31:0] ad, w, input logic p, l, input int nw, nr);
        wbclc_note_t n;
        int k;
        if (we) begin
            view[ad] = w;
        end
        n.rd = !we;
        n.data = exp_word(ad);
        n.nwr = nw;
        n.nrd = nr;
        notes.push_back(n);
        @(posedge REF_CLK);
        #1;
        nwr_seen = 0;
        nrd_seen = 0;
        {cpu_req, cpu_we, cpu_cach, cpu_addr, cpu_wdata, wt_attr, pol} = {1'b1, we, cach, ad, w, p, l};
        k = 0;
        do begin
            @(negedge REF_CLK);
            k++;
        end while (cpu_ready !== 1'b1 && k < 200);
        if (k >= 200) begin
            miscompares++;
            test_done();
        end
        @(posedge REF_CLK);
        #1;
        cpu_req = 1'b0;
    endtask : cpu_op

    // Master stays off the bus while backoff is high
    task automatic snoop(input logic [31:0] ad, input logic iv, input logic hm);
        int k;
        @(posedge REF_CLK);
        #1;
        nwr_seen = 0;
        {strobe, snp_addr, snp_kill} = {1'b1, ad, iv};
        @(posedge REF_CLK);
        #1;
        {strobe, snp_addr, snp_kill} = {1'b0, ~ad, ~iv};
        // Result stands from the first edge after the strobe is taken
        @(negedge REF_CLK);
        check("hit-mod early", 32'h0, {31'h0, snp_hm});
        @(negedge REF_CLK);
        check("hit-mod", {31'h0, hm}, {31'h0, snp_hm});
        check("backoff", {31'h0, hm}, {31'h0, backoff});
        k = 0;
        while (snp_hm !== 1'b0 && k < 100) begin
            @(negedge REF_CLK);
            k++;
        end
        if (k >= 100) begin
            miscompares++;
            test_done();
        end
        check("snoop write beats", hm ? 32'h4 : 32'h0, nwr_seen);
    endtask : snoop

    always @(negedge REF_CLK) begin
        wbclc_note_t n;
        if (bus_req === 1'b1 && bus_ack === 1'b1) begin
            if (bus_we === 1'b1) begin
                nwr_seen++;
                check("bus write data", exp_word(bus_addr), bus_wdata);
            end else begin
                nrd_seen++;
            end
        end
        if (cpu_ready === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            if (n.rd) begin
                check("read data", n.data, cpu_rdata);
            end
            check("write beats", n.nwr, nwr_seen);
            check("read beats", n.nrd, nrd_seen);
        end
    end

    initial begin
        void'($urandom(32'hf6930c18));
        {cpu_req, cpu_we, cpu_cach, wt_attr, pol, strobe, snp_kill} = 7'h0;
        {cpu_addr, cpu_wdata, snp_addr} = {32'h0, 32'h0, 32'h0};
        repeat (5) @(posedge REF_CLK);
        #1;
        ARST_N = 1'b1;
        repeat (3) @(posedge REF_CLK);
        a = mk(1, 0, 0);
        snoop(a, 1'b0, 1'b0);
        cpu_op(0, 1, a, 0, 0, 1, 0, 4);
        cpu_op(0, 1, a, 0, 0, 1, 0, 0);
        cpu_op(0, 1, a + 4, 0, 0, 1, 0, 0);
        cpu_op(1, 1, a, $urandom, 0, 1, 0, 0);
        snoop(a, 1'b0, 1'b1);
        cpu_op(1, 1, a, $urandom, 0, 1, 1, 0);
        cpu_op(0, 1, mk(2, 1, 1), 0, 0, 0, 0, 4);
        cpu_op(1, 1, mk(2, 1, 1), $urandom, 0, 0, 1, 0);
        cpu_op(0, 1, mk(3, 1, 2), 0, 1, 1, 0, 4);
        cpu_op(1, 1, mk(3, 1, 2), $urandom, 1, 1, 1, 0);
        snoop(mk(2, 1, 0), 1'b1, 1'b0);
        cpu_op(0, 1, mk(2, 1, 1), 0, 0, 1, 0, 4);
        cpu_op(1, 1, mk(9, 2, 3), $urandom, 0, 1, 1, 0);
        cpu_op(0, 1, mk(9, 2, 3), 0, 0, 1, 0, 4);
        cpu_op(0, 0, mk(7, 2, 1), 0, 0, 1, 0, 1);
        cpu_op(0, 0, mk(7, 2, 1), 0, 0, 1, 0, 1);
        for (i = 1; i < 5; i++) cpu_op(0, 1, mk(i, 3, 0), 0, 0, 1, 0, 4);
        for (i = 1; i < 5; i++) cpu_op(0, 1, mk(i, 3, 3), 0, 0, 1, 0, 0);
        for (i = 1; i < 5; i++) cpu_op(1, 1, mk(i, 3, i - 1), $urandom, 0, 1, 0, 0);
        cpu_op(0, 1, mk(5, 3, 2), 0, 0, 1, 4, 4);
        cpu_op(0, 1, mk(5, 3, 1), 0, 0, 1, 0, 0);
        test_done();
    end
endmodule : wbclc_top_tb_top

bind wbclc_top wbclc_checker wbclc_checker_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CPU_REQ(CPU_REQ),
    .CPU_READY(CPU_READY), .BUS_REQ(BUS_REQ), .BUS_WE(BUS_WE), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
    .BUS_ACK(BUS_ACK), .SNOOP_ADDRESS_STROBE(SNOOP_ADDRESS_STROBE), .SNOOP_HIT_MODIFIED(SNOOP_HIT_MODIFIED),
    .BUS_BACKOFF(BUS_BACKOFF));
